// [logic/cacr_defs.svh]
// constants of the cascaded converter command register block
// Behaviour
// RULE1 - command byte: read bit then 7-bit address; 0x40 phase, 0x50 rate, 0x60 config, 0x70 results
// RULE2 - phase, config and result payloads are 32, 8 and 96 bits per device
// RULE3 - rate access is always 16 bits and applies to all chained devices
// RULE4 - all phase fields zero samples four channels at one instant
// RULE5 - four 8-bit phase fields, channel 0 on top, 32 clock cycles per step
// RULE6 - configuration resets to zero, six control bits, two low bits reserved zero
// RULE7 - each chained device takes one 8-bit configuration slice
// RULE8 - bit 7 powers down oscillator, fault circuit and bandgap
// RULE9 - bit 6 resets every register but itself and realigns sampling and output
// RULE10 - bit 5 selects 24-bit results, otherwise 19-bit results with tags
// RULE11 - bit 4 enables crystal oscillator and buffered clock output, else tri-state
// RULE12 - bit 3 disables fault protection; otherwise clipped output held for recovery
// RULE13 - bit 2 powers down the internal reference buffer
// RULE14 - results are two's complement
// RULE15 - tagged word: 19-bit result, device position, channel code; full word 24 bits
// RULE16 - each device contributes 96 result bits, channels 0 to 3 in order
// RULE17 - unread results are overwritten by the next conversion silently
// RULE18 - clock idles high, sample on falling, shift on rising, msb first, cs high tri-states
// RULE19 - transfer takes effect at its end; cs rising early discards the write
// RULE20 - tag carries 3-bit device position and 2-bit channel code
// RULE21 - with chain ready low, falling data-ready output announces new results
// RULE22 - host sizes transfers for one to eight devices
`ifndef CACR_DEFS_SVH
`define CACR_DEFS_SVH
`define CACR_ADDR_PHASE 7'h40
`define CACR_ADDR_RATE 7'h50
`define CACR_ADDR_CONFIG 7'h60
`define CACR_ADDR_RESULT 7'h70
`define CACR_PHASE_BITS 32
`define CACR_RATE_BITS 16
`define CACR_CONFIG_BITS 8
`define CACR_RESULT_BITS 96
`define CACR_CONFIG_RESET 8'h00
`define CACR_RATE_RESET 16'h0000
`define CACR_PHASE_RESET 32'h00000000
`define CACR_BIT_PWRDN 7
`define CACR_BIT_SOFTRST 6
`define CACR_BIT_FULLW 5
`define CACR_BIT_XTAL 4
`define CACR_BIT_FLTDIS 3
`define CACR_BIT_REFBUF 2
`define CACR_PHASE_STEP_CYCLES 32
`define CACR_SAMPLE_SPEED_NS 1570000
`define CACR_CLOCK_NS 100
`define CACR_FAULT_HOLD_CYCLES (`CACR_SAMPLE_SPEED_NS / `CACR_CLOCK_NS)
`endif

// [logic/cacr_pkg.sv]
// types of the cascaded converter command register block
package cacr_pkg;
  typedef enum logic [1:0] {
    CACR_CMD = 2'b00,
    CACR_WRITE = 2'b01,
    CACR_READ = 2'b10,
    CACR_IGNORE = 2'b11
  } cacr_state_e;
  typedef struct packed {
    logic powerDown;
    logic softReset;
    logic fullWidth;
    logic crystalOscEnable;
    logic faultProtectDisable;
    logic refbufPowerDown;
    logic [1:0] reserved;
  } cacr_config_s;
  typedef struct packed {
    logic [7:0] ch0PhaseDelay;
    logic [7:0] ch1PhaseDelay;
    logic [7:0] ch2PhaseDelay;
    logic [7:0] ch3PhaseDelay;
  } cacr_phase_s;
  typedef struct packed {
    logic valid;
    logic [3:0][23:0] sample;
  } cacr_sample_s;
endpackage : cacr_pkg

// [logic/cacr_command_registers.sv]
// command decoder, registers and result framing of one chained converter
`timescale 1ns/1ps
`include "cacr_defs.svh"
module cacr_command_registers
  import cacr_pkg::*;
#(
  parameter int FAULT_HOLD_CYCLES = `CACR_FAULT_HOLD_CYCLES
)
(
  // conversion clock domain
  input wire logic clock,
  input wire logic reset_n,
  // serial port, link clock domain
  input wire logic serialClock,
  input wire logic chipSelect_n,
  input wire logic serialDataIn,
  output logic serialDataOut,
  output logic serialDataOutEn,
  // daisy chain
  input wire logic chainDataIn,
  output logic chainDataOut,
  input wire logic chainReadyIn,
  output logic dataReadyOut,
  input wire logic [2:0] devicePositionTag,
  // converter core side
  input wire cacr_sample_s conversionIn,
  input wire logic faultDetected,
  output logic sampleStrobe[4],
  output logic clipOutputs,
  output logic oscillatorOn,
  output logic faultCircuitOn,
  output logic bandgapOn,
  output logic refBufferOn,
  output logic [15:0] outputRate,
  output logic buffered_clock_out,
  output logic buffered_clock_out_en
);
  // ---------------- link domain (serial clock, falling sample / rising shift) -------------
  cacr_state_e state;
  logic [2:0] bitCount;
  logic [6:0] cmdShift;
  logic [6:0] regAddr;
  logic [31:0] inShift;
  logic [6:0] payloadCount;
  logic [95:0] outShift;
  logic writeToggle;
  logic [31:0] writeData;
  logic [6:0] writeAddr;
  logic sliceDone;
  logic readLoaded;
  logic [6:0] payloadLen;
  cacr_phase_s phaseReg;
  logic [15:0] rateReg;
  cacr_config_s configReg;
  logic [95:0] resultReg;
  cacr_phase_s phaseHold;
  logic [15:0] rateHold;
  cacr_config_s configHold;
  logic [95:0] resultHold;
  // payload width per register, one device slice [RULE2] [RULE3]
  always_comb
  begin
    unique case (regAddr)
      `CACR_ADDR_PHASE: payloadLen = 7'(`CACR_PHASE_BITS);
      `CACR_ADDR_RATE: payloadLen = 7'(`CACR_RATE_BITS);
      `CACR_ADDR_CONFIG: payloadLen = 7'(`CACR_CONFIG_BITS);
      default: payloadLen = 7'(`CACR_RESULT_BITS);
    endcase
  end
  // falling edge input sampling, msb first [RULE18]
  always_ff @(negedge serialClock or posedge chipSelect_n)
  begin
    if (chipSelect_n)
    begin
      state <= CACR_CMD; // early raise drops partial writes [RULE19]
      bitCount <= 3'h0;
      cmdShift <= 7'h00;
      regAddr <= 7'h00;
      inShift <= 32'h00000000;
      payloadCount <= 7'h00;
    end
    else
    begin
      unique case (state)
        CACR_CMD:
        begin
          bitCount <= bitCount + 3'h1;
          cmdShift <= {cmdShift[5:0], serialDataIn};
          if (bitCount == 3'h7)
          begin
            regAddr <= {cmdShift[5:0], serialDataIn};
            payloadCount <= 7'h00;
            // read bit then address [RULE1]
            if (cmdShift[6])
              state <= CACR_READ;
            else if ({cmdShift[5:0], serialDataIn} == `CACR_ADDR_RESULT)
              state <= CACR_IGNORE; // result register is read only [RULE1]
            else
              state <= CACR_WRITE;
          end
        end
        CACR_WRITE:
        begin
          inShift <= {inShift[30:0], serialDataIn};
          payloadCount <= payloadCount + 7'h1;
          // a completed slice restarts for the next device in the chain [RULE7]
          if (payloadCount == payloadLen - 7'h1)
            payloadCount <= 7'h00;
        end
        CACR_READ: payloadCount <= payloadCount;
        CACR_IGNORE: payloadCount <= payloadCount;
      endcase
    end
  end
  // a full slice has arrived in this frame; without it a raised cs commits nothing [RULE19]
  always_ff @(negedge serialClock or posedge chipSelect_n)
  begin
    if (chipSelect_n)
      sliceDone <= 1'b0;
    else if (state == CACR_WRITE && payloadCount == payloadLen - 7'h1)
      sliceDone <= 1'b1;
  end
  // the last slice kept when cs rises belongs to this device; commit happens on cs rise
  // only if the slice was complete, so an aborted write is discarded [RULE19] [RULE7]
  always_ff @(posedge chipSelect_n or negedge reset_n)
  begin
    if (!reset_n)
    begin
      writeToggle <= 1'b0;
      writeData <= 32'h00000000;
      writeAddr <= 7'h00;
    end
    else if (state == CACR_WRITE && payloadCount == 7'h00 && sliceDone)
    begin
      writeToggle <= ~writeToggle;
      writeData <= inShift;
      writeAddr <= regAddr;
    end
  end
  // the register word is loaded once per read frame, then only shifted
  always_ff @(posedge serialClock or posedge chipSelect_n)
  begin
    if (chipSelect_n)
      readLoaded <= 1'b0;
    else if (state == CACR_READ)
      readLoaded <= 1'b1;
  end
  // rising edge output shift; chain data follows right behind this word [RULE18] [RULE16]
  always_ff @(posedge serialClock or posedge chipSelect_n)
  begin
    if (chipSelect_n)
    begin
      outShift <= 96'h0;
    end
    else if (state == CACR_READ && !readLoaded)
    begin
      unique case (regAddr)
        `CACR_ADDR_PHASE: outShift <= {phaseHold, 64'h0};
        `CACR_ADDR_RATE: outShift <= {rateHold, 80'h0};
        `CACR_ADDR_CONFIG: outShift <= {configHold, 88'h0};
        default: outShift <= resultHold;
      endcase
    end
    else
    begin
      // chain bits enter just below the word so no padding separates them
      outShift <= {outShift[94:0], 1'b0} | (96'(chainDataIn) << (7'h60 - payloadLen));
    end
  end
  // output tri-stated with cs high [RULE18]
  assign serialDataOut = outShift[95];
  assign serialDataOutEn = !chipSelect_n && state == CACR_READ;
  assign chainDataOut = inShift[31];
  // ---------------- conversion clock domain --------------------------------------------
  logic [2:0] writeSync;
  logic writeLevel;
  logic writeSeen;
  logic [6:0] commitAddr;
  logic [31:0] commitData;
  logic softResetPulse;
  logic [2:0] selectSync;
  logic selectIdle;
  // three-stage toggle crossing; a change counts once stages two and three agree
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      writeSync <= 3'h0;
      writeLevel <= 1'b0;
      writeSeen <= 1'b0;
    end
    else
    begin
      writeSync <= {writeSync[1:0], writeToggle};
      writeSeen <= writeSync[2] == writeSync[1] && writeSync[2] != writeLevel;
      if (writeSync[2] == writeSync[1])
        writeLevel <= writeSync[2];
    end
  end
  // address and data are stable long before the toggle is seen
  assign commitAddr = writeAddr;
  assign commitData = writeData;
  assign softResetPulse = writeSeen && commitAddr == `CACR_ADDR_CONFIG
    && commitData[`CACR_BIT_SOFTRST];
  // register writes; soft reset returns all but its own bit to default [RULE9] [RULE6]
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phaseReg <= `CACR_PHASE_RESET;
      rateReg <= `CACR_RATE_RESET;
      configReg <= `CACR_CONFIG_RESET;
    end
    else if (softResetPulse)
    begin
      phaseReg <= `CACR_PHASE_RESET;
      rateReg <= `CACR_RATE_RESET;
      configReg <= `CACR_CONFIG_RESET | (8'h01 << `CACR_BIT_SOFTRST); // [RULE9]
    end
    else if (writeSeen)
    begin
      unique case (commitAddr)
        `CACR_ADDR_PHASE: phaseReg <= commitData; // [RULE5]
        `CACR_ADDR_RATE: rateReg <= commitData[15:0]; // broadcast to all [RULE3]
        `CACR_ADDR_CONFIG: configReg <= {commitData[7:2], 2'b00}; // [RULE6] [RULE7]
        default: rateReg <= rateReg;
      endcase
    end
  end
  // chip select brought into the conversion domain; a change counts once stages agree
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      selectSync <= 3'h7;
      selectIdle <= 1'b1;
    end
    else
    begin
      selectSync <= {selectSync[1:0], chipSelect_n};
      if (selectSync[2] == selectSync[1])
        selectIdle <= selectSync[2];
    end
  end
  // register copies frozen while a frame is open, so the link side loads a settled word;
  // the freeze lands well before the command byte ends, and a conversion during a
  // read is only seen by the next read
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phaseHold <= `CACR_PHASE_RESET;
      rateHold <= `CACR_RATE_RESET;
      configHold <= `CACR_CONFIG_RESET;
      resultHold <= 96'h0;
    end
    else if (selectIdle)
    begin
      phaseHold <= phaseReg;
      rateHold <= rateReg;
      configHold <= configReg;
      resultHold <= resultReg;
    end
  end
  // control outputs from configuration bits [RULE8] [RULE11] [RULE13]
  assign oscillatorOn = configReg.crystalOscEnable && !configReg.powerDown;
  assign faultCircuitOn = !configReg.powerDown && !configReg.faultProtectDisable;
  assign bandgapOn = !configReg.powerDown;
  assign refBufferOn = !configReg.refbufPowerDown;
  assign outputRate = rateReg;
  assign buffered_clock_out = clock;
  assign buffered_clock_out_en = oscillatorOn; // tri-state when disabled [RULE11]
  // per-channel sampling delay, 32 cycles per step; zero means simultaneous [RULE4] [RULE5]
  logic [12:0] phaseTimer;
  logic frameStart;
  assign frameStart = conversionIn.valid || softResetPulse; // realign [RULE9]
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      phaseTimer <= 13'h1fff;
    else if (frameStart)
      phaseTimer <= 13'h0001; // count k lands k cycles after the reference instant
    else if (phaseTimer != 13'h1fff)
      phaseTimer <= phaseTimer + 13'h0001;
  end
  for (genvar ch = 0; ch < 4; ch++)
  begin : g_phase
    logic [7:0] delayField;
    assign delayField = phaseReg[31-8*ch -: 8];
    assign sampleStrobe[ch] = (delayField == 8'h00) ? frameStart
      : (phaseTimer == 13'({delayField, 5'h00}));
  end
  // fault recovery hold unless protection disabled or powered down [RULE12]
  logic [31:0] faultHold;
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      faultHold <= 32'h0;
    else if (configReg.faultProtectDisable || configReg.powerDown)
      faultHold <= 32'h0;
    else if (faultDetected)
      faultHold <= 32'(FAULT_HOLD_CYCLES);
    else if (faultHold != 32'h0)
      faultHold <= faultHold - 32'h1;
  end
  assign clipOutputs = faultDetected && !configReg.faultProtectDisable || faultHold != 32'h0;
  // result framing, new each conversion [RULE10] [RULE14] [RULE15] [RULE16] [RULE17] [RULE20]
  function automatic logic [23:0] fmtWord(input logic [23:0] s, input logic [1:0] ch,
    input logic full, input logic [2:0] pos);
    fmtWord = full ? s : {s[23:5], pos, ch};
  endfunction : fmtWord
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      resultReg <= 96'h0;
    else if (softResetPulse)
      resultReg <= 96'h0;
    else if (conversionIn.valid)
      resultReg <= {fmtWord(conversionIn.sample[0], 2'b00, configReg.fullWidth, devicePositionTag),
        fmtWord(conversionIn.sample[1], 2'b01, configReg.fullWidth, devicePositionTag),
        fmtWord(conversionIn.sample[2], 2'b10, configReg.fullWidth, devicePositionTag),
        fmtWord(conversionIn.sample[3], 2'b11, configReg.fullWidth, devicePositionTag)};
  end
  // data ready falls on new results while chain ready is low [RULE21]
  logic [2:0] chainReadySync;
  logic chainReadyLevel;
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      chainReadySync <= 3'h7;
      chainReadyLevel <= 1'b1;
      dataReadyOut <= 1'b1;
    end
    else
    begin
      chainReadySync <= {chainReadySync[1:0], chainReadyIn};
      if (chainReadySync[2] == chainReadySync[1])
        chainReadyLevel <= chainReadySync[2];
      if (conversionIn.valid && !chainReadyLevel)
        dataReadyOut <= 1'b0;
      else if (writeSeen || conversionIn.valid)
        dataReadyOut <= 1'b1;
    end
  end
endmodule : cacr_command_registers

// [tb/cacr_serial_host.sv]
// serial host model driving the converter command port
`timescale 1ns/1ps
module cacr_serial_host
(
  // serial port
  output logic serialClock,
  output logic chipSelect_n,
  output logic serialDataIn,
  input wire logic serialDataOut
);
  // clock idles high and stands still between frames
  initial
  begin
    serialClock = 1'b1;
    chipSelect_n = 1'b1;
    serialDataIn = 1'b0;
  end
  // command byte, then nSent of nPay payload bits, msb first; read bits taken on falling edges
  task automatic xfer(input logic [7:0] cmd, input int nPay, input int nSent,
    input logic [95:0] wData, output logic [95:0] rData);
    rData = '0;
    chipSelect_n = 1'b0;
    for (int i = 0; i < 8 + nSent; i++)
    begin
      serialDataIn = (i < 8) ? cmd[7 - i] : wData[nPay + 7 - i];
      #32 serialClock = 1'b0;
      if (i >= 8)
        rData = {rData[94:0], serialDataOut};
      #32 serialClock = 1'b1;
    end
    #32 chipSelect_n = 1'b1;
    serialDataIn = ~serialDataIn; // released line shows no stale value
    #800; // frame gap of eight conversion clocks
  endtask : xfer
endmodule : cacr_serial_host

// [tb/cacr_command_registers_monitor.sv]
// concurrent checks on the command register block ports
`timescale 1ns/1ps
module cacr_command_registers_monitor
  import cacr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // serial and chain
  input wire logic chipSelect_n,
  input wire logic serialDataOutEn,
  input wire logic chainReadyIn,
  input wire logic dataReadyOut,
  // core side
  input wire cacr_sample_s conversionIn,
  input wire logic faultDetected,
  input wire logic clipOutputs,
  input wire logic oscillatorOn,
  input wire logic faultCircuitOn,
  input wire logic bandgapOn,
  input wire logic refBufferOn,
  input wire logic [15:0] outputRate,
  input wire logic buffered_clock_out_en
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  out_tristate_a: assert property (chipSelect_n [*2] |-> !serialDataOutEn)
    else $error("data output driven while deselected");
  reset_state_a: assert property ($rose(reset_n) |-> dataReadyOut && bandgapOn && !oscillatorOn)
    else $error("wrong state after reset");
  power_down_a: assert property (!bandgapOn |-> !oscillatorOn && !faultCircuitOn)
    else $error("circuits on in power down");
  clock_out_a: assert property (buffered_clock_out_en |-> oscillatorOn && bandgapOn)
    else $error("clock output without oscillator");
  rate_stable_a: assert property (chipSelect_n [*8] |-> $stable(outputRate))
    else $error("rate changed outside a transfer");
  clip_start_a: assert property (faultDetected && faultCircuitOn |-> ##[0:2] clipOutputs)
    else $error("fault not clipped");
  clip_hold_a: assert property ($fell(faultDetected) && faultCircuitOn |-> clipOutputs [*8])
    else $error("clip released early");
  ready_fall_a: assert property (conversionIn.valid && !chainReadyIn |-> ##[1:4] !dataReadyOut)
    else $error("data ready not lowered");
  frame_c: cover property ($fell(chipSelect_n));
  ready_c: cover property ($fell(dataReadyOut));
  clip_c: cover property ($rose(clipOutputs));
endmodule : cacr_command_registers_monitor
bind cacr_command_registers cacr_command_registers_monitor u_cacr_command_registers_monitor (
  .clock(clock), .reset_n(reset_n), .chipSelect_n(chipSelect_n),
  .serialDataOutEn(serialDataOutEn), .chainReadyIn(chainReadyIn), .dataReadyOut(dataReadyOut),
  .conversionIn(conversionIn), .faultDetected(faultDetected), .clipOutputs(clipOutputs),
  .oscillatorOn(oscillatorOn), .faultCircuitOn(faultCircuitOn), .bandgapOn(bandgapOn),
  .refBufferOn(refBufferOn), .outputRate(outputRate), .buffered_clock_out_en(buffered_clock_out_en));

// [tb/cacr_command_registers_tb.sv]
// self-checking bench of the converter command registers
`timescale 1ns/1ps
module cacr_command_registers_tb;
  import cacr_pkg::*;
  logic clock, reset_n, serialClock, chipSelect_n, serialDataIn, serialDataOut, serialDataOutEn;
  logic chainDataOut, dataReadyOut, clipOutputs, oscillatorOn, faultCircuitOn;
  logic bandgapOn, refBufferOn, bufClockOut, bufClockOutEn;
  logic chainDataIn = 1'b0;
  logic chainReadyIn = 1'b0;
  logic faultDetected = 1'b0;
  logic [2:0] devicePositionTag = 3'h5;
  logic [15:0] outputRate;
  logic sampleStrobe[4];
  cacr_sample_s conversionIn = '0;
  logic [95:0] rd;
  logic [3:0][23:0] smp = {24'hfffff1, 24'h00ff00, 24'h7abcde, 24'h812345};
  int n_errors, cmp_count, cycles;
  // device and host
  cacr_command_registers #(.FAULT_HOLD_CYCLES(20)) u_cacr_command_registers (.clock(clock),
    .reset_n(reset_n), .serialClock(serialClock), .chipSelect_n(chipSelect_n),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut), .serialDataOutEn(serialDataOutEn),
    .chainDataIn(chainDataIn), .chainDataOut(chainDataOut), .chainReadyIn(chainReadyIn),
    .dataReadyOut(dataReadyOut), .devicePositionTag(devicePositionTag),
    .conversionIn(conversionIn), .faultDetected(faultDetected), .sampleStrobe(sampleStrobe),
    .clipOutputs(clipOutputs), .oscillatorOn(oscillatorOn), .faultCircuitOn(faultCircuitOn),
    .bandgapOn(bandgapOn), .refBufferOn(refBufferOn), .outputRate(outputRate),
    .buffered_clock_out(bufClockOut), .buffered_clock_out_en(bufClockOutEn));
  cacr_serial_host u_cacr_serial_host (.serialClock(serialClock), .chipSelect_n(chipSelect_n),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut));
  // 10 MHz clock and hang guard
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 10000)
    begin
      n_errors++;
      final_report();
    end
  end
  task automatic final_report;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one single-device frame through the host model
  task automatic x(input logic [7:0] cmd, input int nPay, input int nSent, input logic [95:0] w);
    u_cacr_serial_host.xfer(cmd, nPay, nSent, w, rd);
  endtask : x
  // one conversion result from the core side
  task automatic convert(input logic [3:0][23:0] s);
    @(posedge clock);
    conversionIn <= '{valid: 1'b1, sample: s};
    @(posedge clock);
    conversionIn.valid <= 1'b0;
    repeat (10) @(posedge clock);
  endtask : convert
  task automatic t_reset;
    x(8'he0, 8, 8, '0);
    chk("config", 96'h00, rd);
    chk("ready", 96'h1, 96'(dataReadyOut));
  endtask : t_reset
  task automatic t_config;
    x(8'h60, 8, 8, 96'h17);
    x(8'he0, 8, 8, '0);
    chk("config", 96'h14, rd);
    chk("osc", 96'h1, 96'({oscillatorOn, bufClockOutEn} == 2'b11));
    chk("refbuf", 96'h0, 96'(refBufferOn));
    x(8'h60, 8, 8, 96'h88);
    chk("power", 96'h0, 96'({bandgapOn, oscillatorOn, faultCircuitOn}));
    x(8'h60, 8, 8, 96'h00);
    chk("power", 96'h7, 96'({bandgapOn, refBufferOn, faultCircuitOn}));
    @(posedge clock);
    chainDataIn <= 1'b1;
    x(8'he0, 16, 16, '0);
    chk("chain", 96'h00ff, rd);
    @(posedge clock);
    chainDataIn <= 1'b0;
  endtask : t_config
  task automatic t_phase;
    int seen[4] = '{-1, -1, -1, -1};
    x(8'h40, 32, 32, 96'h00010000);
    @(posedge clock);
    conversionIn <= '{valid: 1'b1, sample: smp};
    for (int k = 0; k < 40; k++)
    begin
      @(posedge clock);
      conversionIn.valid <= 1'b0;
      for (int c = 0; c < 4; c++)
        if (sampleStrobe[c])
          seen[c] = k;
    end
    chk("strobe0", 96'h0, 96'(seen[0]));
    chk("strobe1", 96'h20, 96'(seen[1]));
    chk("strobe23", 96'h0, 96'(seen[2] | seen[3]));
    chk("ready", 96'h0, 96'(dataReadyOut));
  endtask : t_phase
  task automatic t_regs;
    x(8'h50, 16, 16, 96'hbeef);
    chk("rate", 96'hbeef, 96'(outputRate));
    x(8'h50, 16, 10, 96'h1234);
    x(8'hd0, 16, 16, '0);
    chk("rate", 96'hbeef, rd);
    x(8'h40, 32, 32, 96'h01020304);
    x(8'hc0, 32, 32, '0);
    chk("phase", 96'h01020304, rd);
  endtask : t_regs
  task automatic t_results;
    logic [95:0] exp;
    convert({24'h0, 24'h0, 24'h0, 24'h1});
    convert(smp);
    for (int c = 0; c < 4; c++)
      exp[95 - 24 * c -: 24] = {smp[c][23:5], devicePositionTag, 2'(c)};
    x(8'hf0, 96, 96, '0);
    chk("tagged", exp, rd);
    x(8'h60, 8, 8, 96'h20);
    convert(smp);
    x(8'hf0, 96, 96, '0);
    chk("full", {smp[0], smp[1], smp[2], smp[3]}, rd);
  endtask : t_results
  task automatic t_soft;
    x(8'h60, 8, 8, 96'h40);
    x(8'hd0, 16, 16, '0);
    chk("rate", 96'h0, rd);
    x(8'hc0, 32, 32, '0);
    chk("phase", 96'h0, rd);
    x(8'h60, 8, 8, 96'h00);
  endtask : t_soft
  task automatic t_fault;
    @(posedge clock);
    faultDetected <= 1'b1;
    repeat (4) @(posedge clock);
    chk("clip", 96'h1, 96'(clipOutputs));
    faultDetected <= 1'b0;
    repeat (10) @(posedge clock);
    chk("clip hold", 96'h1, 96'(clipOutputs));
    repeat (20) @(posedge clock);
    chk("clip", 96'h0, 96'(clipOutputs));
  endtask : t_fault
  // reset, then scenarios
  initial
  begin
    reset_n = 1'b0;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset();
    t_config();
    t_regs();
    t_phase();
    t_results();
    t_soft();
    t_fault();
    final_report();
  end
endmodule : cacr_command_registers_tb
